// >>> src/ect_top.sv
// Purpose: 8-bit up-counter with rising and falling edge capture
// Assumes: registers reached over the 8-bit peripheral bus
// Notes: read data is returned one cycle after rd_i
`timescale 1ns/1ps
`include "ect_defines.svh"
`default_nettype none
module ect_top (
	input wire logic sys_clk_i, // system clock, 10 MHz
	input wire logic nrst_i, // async reset, active low
	input wire logic ce_i, // clock enable, freezes state when low
	input wire logic [15:0] addr_i, // register byte address
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [7:0] wdata_i, // write data
	output logic [7:0] rdata_o, // read data, next cycle
	input wire logic cap_pin_i, // capture input pin
	input wire logic capture_input_pin_select_i, // 1 selects capture
	input wire logic noise_filter_select_i, // 1 enables filter
	input wire logic subclk_i, // subclock
	input wire logic sub_power_mode_i, // watch/subactive/subsleep
	input wire logic timer_irq_enable_i, // interrupt enable
	input wire logic timer_irq_flag_clr_i, // clears request flag
	output logic timer_irq_request_flag_o, // request flag
	output logic timer_irq_o // interrupt to the cpu
);
	logic [7:0] cnt_q, cnt_d;
	logic [7:0] fall_cap_q, rise_cap_q;
	logic [5:0] mode_ctl_q;
	logic overflow_at_high_level_q, overflow_at_low_level_q;
	logic [1:0] arm_q;
	logic [7:0] ckstp_q;
	logic [7:0] rdata_q;
	logic flag_q, irq_q, prev_q;
	logic tick, lvl, clr_evt;
	logic [7:0] rd_mux;

	ect_pkg::ect_clk_sel_t cks;
	ect_pkg::ect_clr_sel_t cclr;
	assign cks = ect_pkg::ect_clk_sel_t'(mode_ctl_q[`ECT_BIT_CKS_HI:`ECT_BIT_CKS_LO]);
	assign cclr = ect_pkg::ect_clr_sel_t'(mode_ctl_q[`ECT_BIT_CCLR_HI:`ECT_BIT_CCLR_LO]);

	wire overflow_irq_enable = mode_ctl_q[`ECT_BIT_OVERFLOW_IRQ_ENABLE];
	wire capture_irq_edge_select = mode_ctl_q[`ECT_BIT_CAPTURE_IRQ_EDGE_SELECT];
	wire run = ckstp_q[`ECT_BIT_STBY];
	wire go = ce_i & run;

	ect_prescaler u_pre (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.sel_i(cks),
		.subclk_i(subclk_i),
		.tick_o(tick)
	);

	ect_noise_filter u_filt (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.pin_i(cap_pin_i),
		.en_i(noise_filter_select_i),
		.lvl_o(lvl)
	);

	// input gated by pin select; toggling the select can itself make an edge
	wire cap_in = capture_input_pin_select_i & lvl;
	wire rise = cap_in & ~prev_q;
	wire fall = ~cap_in & prev_q;

	// low-power states only count on the subclock tap
	wire sub_ok = ~sub_power_mode_i | (cks == ect_pkg::ECT_CK_SUB2);
	wire cnt_en = tick & sub_ok;

	always_comb begin
		case (cclr)
			ect_pkg::ECT_CLR_NONE: clr_evt = 1'b0;
			ect_pkg::ECT_CLR_FALL: clr_evt = fall;
			ect_pkg::ECT_CLR_RISE: clr_evt = rise;
			ect_pkg::ECT_CLR_BOTH: clr_evt = fall | rise;
			default: clr_evt = 1'b0;
		endcase
	end

	wire ovf = cnt_en & ~clr_evt & (cnt_q == 8'hFF);

	always_comb begin
		cnt_d = cnt_q;
		if (clr_evt)
			cnt_d = `ECT_RST_CNT;
		else if (cnt_en)
			cnt_d = cnt_q + 8'h01;
	end

	// bus decode
	wire sel_mode = addr_i == `ECT_ADDR_MODE;
	wire sel_fall = addr_i == `ECT_ADDR_FALL;
	wire sel_rise = addr_i == `ECT_ADDR_RISE;
	wire sel_ckstp = addr_i == `ECT_ADDR_CKSTP;
	wire wr_mode = wr_i & sel_mode;
	wire rd_mode = rd_i & sel_mode;

	// flags clear only by a 0 written after a 1 was read; a set wins
	wire overflow_at_high_level_set = go & ovf & cap_in;
	wire overflow_at_low_level_set = go & ovf & ~cap_in;
	wire overflow_at_high_level_clr = wr_mode & ~wdata_i[`ECT_BIT_OVERFLOW_AT_HIGH_LEVEL] & arm_q[1];
	wire overflow_at_low_level_clr = wr_mode & ~wdata_i[`ECT_BIT_OVERFLOW_AT_LOW_LEVEL] & arm_q[0];
	wire overflow_at_high_level_d = overflow_at_high_level_set | (overflow_at_high_level_q & ~overflow_at_high_level_clr);
	wire overflow_at_low_level_d = overflow_at_low_level_set | (overflow_at_low_level_q & ~overflow_at_low_level_clr);

	// capture interrupt on the chosen edge, overflow when enabled
	wire cap_irq = capture_irq_edge_select ? fall : rise;
	wire flag_set = go & ((ovf & overflow_irq_enable) | cap_irq);
	wire flag_d = flag_set | (flag_q & ~timer_irq_flag_clr_i);

	always_comb begin
		rd_mux = 8'h00;
		if (sel_mode)
			rd_mux = {overflow_at_high_level_q, overflow_at_low_level_q, mode_ctl_q};
		else if (sel_fall)
			rd_mux = fall_cap_q;
		else if (sel_rise)
			rd_mux = rise_cap_q;
		else if (sel_ckstp)
			rd_mux = ckstp_q;
	end

	// counter, captures and edge history run only out of standby
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= `ECT_RST_CNT;
			fall_cap_q <= `ECT_RST_CAP;
			rise_cap_q <= `ECT_RST_CAP;
			prev_q <= 1'b0;
		end else if (go) begin
			cnt_q <= cnt_d;
			prev_q <= cap_in;
			if (fall)
				fall_cap_q <= cnt_q;
			if (rise)
				rise_cap_q <= cnt_q;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_ctl_q <= 6'(`ECT_RST_MODE);
		end else if (ce_i && wr_mode) begin
			mode_ctl_q <= wdata_i[5:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			overflow_at_high_level_q <= 1'b0;
			overflow_at_low_level_q <= 1'b0;
			arm_q <= 2'h0;
		end else if (ce_i) begin
			overflow_at_high_level_q <= overflow_at_high_level_d;
			overflow_at_low_level_q <= overflow_at_low_level_d;
			if (wr_mode)
				arm_q <= 2'h0;
			else if (rd_mode)
				arm_q <= arm_q | {overflow_at_high_level_q, overflow_at_low_level_q};
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ckstp_q <= `ECT_RST_CKSTP;
			rdata_q <= 8'h00;
		end else if (ce_i) begin
			if (wr_i && sel_ckstp)
				ckstp_q <= wdata_i;
			if (rd_i)
				rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce_i) begin
			flag_q <= flag_d;
			irq_q <= flag_q & timer_irq_enable_i;
		end
	end

	assign rdata_o = rdata_q;
	assign timer_irq_request_flag_o = flag_q;
	assign timer_irq_o = irq_q;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_count_step: assert property (go && cnt_en && !clr_evt |=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("counter did not advance on a count pulse");
	a_edge_clear: assert property (go && clr_evt |=> cnt_q == 8'h00)
		else $error("counter not cleared on selected capture edge");
	a_no_clear_sel: assert property (go && cclr == ect_pkg::ECT_CLR_NONE && !cnt_en |=> cnt_q == $past(cnt_q))
		else $error("counter changed with clearing disabled and no tick");
	a_fall_capture: assert property (go && fall |=> fall_cap_q == $past(cnt_q))
		else $error("falling capture lost the counter value");
	a_rise_capture: assert property (go && rise |=> rise_cap_q == $past(cnt_q))
		else $error("rising capture lost the counter value");
	a_ovf_irq_flag: assert property (go && ovf && overflow_irq_enable |=> flag_q ##1 (irq_q == $past(timer_irq_enable_i)))
		else $error("overflow did not raise the request");
	a_fall_irq_sel: assert property (go && fall && capture_irq_edge_select |=> flag_q)
		else $error("falling capture with edge select did not set flag");
	a_ovf_level_hi: assert property (go && ovf && cap_in |=> overflow_at_high_level_q && ($stable(overflow_at_low_level_q) || $past(overflow_at_low_level_clr)))
		else $error("high-level overflow not recorded");
	a_ovf_level_lo: assert property (go && ovf && !cap_in |=> overflow_at_low_level_q)
		else $error("low-level overflow not recorded");
	a_ovf_sticky: assert property (ce_i && overflow_at_high_level_q && !(wr_mode && !wdata_i[`ECT_BIT_OVERFLOW_AT_HIGH_LEVEL]) |=> overflow_at_high_level_q)
		else $error("high overflow flag lost without a clearing write");
	a_standby_hold: assert property (ce_i && !run |=> $stable(cnt_q) && $stable(fall_cap_q))
		else $error("timer moved in module standby");
	a_sub_hold: assert property (ce_i && sub_power_mode_i && cks != ect_pkg::ECT_CK_SUB2 && !clr_evt
		|=> $stable(cnt_q))
		else $error("counter ran on a main-clock tap in low power");

	a_fall_read: assert property (ce_i && rd_i && sel_fall |=> rdata_q == $past(fall_cap_q))
		else $error("falling capture read returned wrong data");

	a_rise_read: assert property (ce_i && rd_i && sel_rise |=> rdata_q == $past(rise_cap_q))
		else $error("rising capture read returned wrong data");

	a_fall_hold: assert property (!(go && fall) |=> $stable(fall_cap_q))
		else $error("falling capture changed without a falling edge");

	a_rise_hold: assert property (!(go && rise) |=> $stable(rise_cap_q))
		else $error("rising capture changed without a rising edge");

	a_rise_clear: assert property (go && rise && cclr == ect_pkg::ECT_CLR_RISE |=> cnt_q == 8'h00)
		else $error("counter not cleared on rising edge");

	a_fall_clear: assert property (go && fall && cclr == ect_pkg::ECT_CLR_FALL |=> cnt_q == 8'h00)
		else $error("counter not cleared on falling edge");

	a_both_clear: assert property (go && (rise || fall) && cclr == ect_pkg::ECT_CLR_BOTH |=> cnt_q == 8'h00)
		else $error("counter not cleared on either edge");

	a_rise_irq_sel: assert property (go && rise && !capture_irq_edge_select |=> flag_q)
		else $error("rising capture did not set flag");

	a_flag_sticky: assert property (ce_i && flag_q && !timer_irq_flag_clr_i |=> flag_q)
		else $error("request flag lost without a clear");

	a_irq_follow: assert property (ce_i |=> irq_q == ($past(flag_q) && $past(timer_irq_enable_i)))
		else $error("interrupt does not follow flag and enable");

	a_standby_flag: assert property (ce_i && !run && !flag_q |=> !flag_q)
		else $error("flag set while in module standby");

	a_ovf_wrap: assert property (go && ovf |=> cnt_q == 8'h00)
		else $error("counter did not wrap to zero");

	a_ckstp_write: assert property (ce_i && wr_i && sel_ckstp |=> ckstp_q == $past(wdata_i))
		else $error("clock stop write lost");

	a_interval_no_cap: assert property (!capture_input_pin_select_i |=> $stable(rise_cap_q))
		else $error("capture taken in interval operation");

	a_overflow_at_low_level_interval: assert property (go && ovf && !capture_input_pin_select_i |=> overflow_at_low_level_q)
		else $error("interval overflow not recorded as low");

	a_overflow_at_low_level_clear: assert property (ce_i && overflow_at_low_level_clr && !overflow_at_low_level_set |=> !overflow_at_low_level_q)
		else $error("low overflow flag not cleared");

	a_overflow_at_high_level_clear: assert property (ce_i && overflow_at_high_level_clr && !overflow_at_high_level_set |=> !overflow_at_high_level_q)
		else $error("high overflow flag not cleared");

	a_overflow_at_low_level_unarmed: assert property (ce_i && overflow_at_low_level_q && !arm_q[0] |=> overflow_at_low_level_q)
		else $error("low overflow flag cleared without a read");

	c_ovf_high: cover property (go && ovf && cap_in);
	c_sub_tick: cover property (go && cnt_en && cks == ect_pkg::ECT_CK_SUB2);
	c_both_clear: cover property (go && cclr == ect_pkg::ECT_CLR_BOTH && rise ##[1:200] go && fall);
	c_fall_irq: cover property (go && fall && capture_irq_edge_select ##2 irq_q);
	c_flag_clear: cover property (rd_mode && overflow_at_low_level_q ##1 wr_mode && !wdata_i[`ECT_BIT_OVERFLOW_AT_LOW_LEVEL]);
endmodule
`default_nettype wire

// >>> src/ect_defines.svh
// Purpose: constants for the 8-bit edge capture timer
// Assumes: 8-bit peripheral bus with 16-bit byte addresses
// Notes: offsets, field positions, reset values and counts
`ifndef ECT_DEFINES_SVH
`define ECT_DEFINES_SVH

`define ECT_ADDR_MODE 16'hFFBC
`define ECT_ADDR_FALL 16'hFFBD
`define ECT_ADDR_RISE 16'hFFBE
`define ECT_ADDR_CKSTP 16'hFFFA

`define ECT_BIT_OVERFLOW_AT_HIGH_LEVEL 7
`define ECT_BIT_OVERFLOW_AT_LOW_LEVEL 6
`define ECT_BIT_OVERFLOW_IRQ_ENABLE 5
`define ECT_BIT_CAPTURE_IRQ_EDGE_SELECT 4
`define ECT_BIT_CCLR_HI 3
`define ECT_BIT_CCLR_LO 2
`define ECT_BIT_CKS_HI 1
`define ECT_BIT_CKS_LO 0
`define ECT_BIT_STBY 3

`define ECT_RST_MODE 8'h00
`define ECT_RST_CAP 8'h00
`define ECT_RST_CNT 8'h00
`define ECT_RST_CKSTP 8'hFF

`define ECT_DIV_A 64
`define ECT_DIV_B 32
`define ECT_DIV_C 2
`define ECT_FILT_LEN 4

`endif

// >>> src/ect_pkg.sv
// Purpose: types for the 8-bit edge capture timer
// Assumes: nothing
// Notes: encodings match the mode register fields
package ect_pkg;
	typedef enum logic [1:0] {
		ECT_CK_DIV64 = 2'h0,
		ECT_CK_DIV32 = 2'h1,
		ECT_CK_DIV2 = 2'h2,
		ECT_CK_SUB2 = 2'h3
	} ect_clk_sel_t;

	typedef enum logic [1:0] {
		ECT_CLR_NONE = 2'h0,
		ECT_CLR_FALL = 2'h1,
		ECT_CLR_RISE = 2'h2,
		ECT_CLR_BOTH = 2'h3
	} ect_clr_sel_t;
endpackage

// >>> src/ect_prescaler.sv
// Purpose: count clock taps for the capture timer
// Assumes: subclock is slow against the system clock
// Notes: tick_o is a one-cycle pulse on the selected tap
`timescale 1ns/1ps
`include "ect_defines.svh"
`default_nettype none
module ect_prescaler #(
	parameter int DIV_W = $clog2(`ECT_DIV_A)
) (
	input wire logic sys_clk_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic ce_i, // clock enable
	input wire ect_pkg::ect_clk_sel_t sel_i, // tap select
	input wire logic subclk_i, // subclock, asynchronous
	output logic tick_o // count pulse
);
	logic [DIV_W-1:0] div_q;
	logic sub_s1_q, sub_s2_q, sub_s3_q, sub_half_q;
	wire sub_rise = sub_s2_q & ~sub_s3_q;

	// true on the last cycle of each period of length n (power of two)
	function automatic logic tap(input logic [DIV_W-1:0] d, input int n);
		logic [DIV_W-1:0] m;
		m = DIV_W'(n - 1);
		return (d & m) == m;
	endfunction

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_q <= '0;
			sub_s1_q <= 1'b0;
			sub_s2_q <= 1'b0;
			sub_s3_q <= 1'b0;
			sub_half_q <= 1'b0;
		end else if (ce_i) begin
			div_q <= div_q + DIV_W'(1);
			sub_s1_q <= subclk_i;
			sub_s2_q <= sub_s1_q;
			sub_s3_q <= sub_s2_q;
			if (sub_rise)
				sub_half_q <= ~sub_half_q;
		end
	end

	always_comb begin
		case (sel_i)
			ect_pkg::ECT_CK_DIV64: tick_o = tap(div_q, `ECT_DIV_A);
			ect_pkg::ECT_CK_DIV32: tick_o = tap(div_q, `ECT_DIV_B);
			ect_pkg::ECT_CK_DIV2: tick_o = tap(div_q, `ECT_DIV_C);
			ect_pkg::ECT_CK_SUB2: tick_o = sub_rise & sub_half_q;
			default: tick_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// >>> src/ect_noise_filter.sv
// Purpose: synchronise and optionally deglitch the capture pin
// Assumes: pin is asynchronous to the system clock
// Notes: filtered level moves only after LEN equal samples
`timescale 1ns/1ps
`include "ect_defines.svh"
`default_nettype none
module ect_noise_filter #(
	parameter int LEN = `ECT_FILT_LEN
) (
	input wire logic sys_clk_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic ce_i, // clock enable
	input wire logic pin_i, // raw capture pin
	input wire logic en_i, // filter on
	output logic lvl_o // clean level
);
	logic s1_q, s2_q, filt_q;
	logic [LEN-1:0] hist_q;
	wire all_hi = &hist_q;
	wire all_lo = ~|hist_q;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			hist_q <= '0;
			filt_q <= 1'b0;
		end else if (ce_i) begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			hist_q <= {hist_q[LEN-2:0], s2_q};
			if (all_hi)
				filt_q <= 1'b1;
			else if (all_lo)
				filt_q <= 1'b0;
		end
	end

	assign lvl_o = en_i ? filt_q : s2_q;
endmodule
`default_nettype wire

// >>> verification/ect_pulse_src.sv
// Purpose: pulse source model on the capture pin
// Assumes: bench raises fire_i for one clock
// Notes: idle high, low pulse of width_i clocks
`timescale 1ns/1ps
`default_nettype none
module ect_pulse_src (
	input wire logic sys_clk_i, // system clock
	input wire logic fire_i, // start a pulse
	input wire logic [7:0] width_i, // low time in clocks
	output logic pin_o // capture pin
);
	int n = 0;
	initial pin_o = 1'b1;
	always @(posedge sys_clk_i) begin
		if (n > 0) begin
			n <= n - 1;
			if (n == 1) pin_o <= 1'b1;
		end else if (fire_i) begin
			n <= (width_i < 8'h02) ? 2 : int'(width_i);
			pin_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Purpose: bench for the edge capture timer
// Assumes: pulse source model drives the capture pin
// Notes: one task per scenario
`timescale 1ns/1ps
`include "ect_defines.svh"
`default_nettype none
module tb;
	logic clk = 0, nrst = 0, wr_s = 0, rd_s = 0, fire = 0, nf = 0;
	logic sub = 0, spm = 0, psel = 0, fclr = 0, ce = 1, ien = 1;
	logic [15:0] addr = '0;
	logic [7:0] wd = '0, width = '0, rdata;
	logic pin, flag, irq;
	int n_errors = 0, comparisons = 0;
	ect_top dut_u (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .addr_i(addr), .wr_i(wr_s),
		.rd_i(rd_s), .wdata_i(wd), .rdata_o(rdata), .cap_pin_i(pin),
		.capture_input_pin_select_i(psel), .noise_filter_select_i(nf), .subclk_i(sub),
		.sub_power_mode_i(spm), .timer_irq_enable_i(ien), .timer_irq_flag_clr_i(fclr),
		.timer_irq_request_flag_o(flag), .timer_irq_o(irq));
	ect_pulse_src src_u (.sys_clk_i(clk), .fire_i(fire), .width_i(width), .pin_o(pin));
	initial forever #50 clk = ~clk;
	initial forever #400 sub = ~sub;
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr_s = 1'b1;
		@(negedge clk);
		wr_s = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd_s = 1'b1;
		@(negedge clk);
		rd_s = 1'b0;
		d = rdata;
	endtask
	task automatic clr;
		@(negedge clk);
		fclr = 1'b1;
		@(negedge clk);
		fclr = 1'b0;
	endtask
	task automatic pulse(input logic [7:0] w);
		@(negedge clk);
		width = w;
		fire = 1'b1;
		@(negedge clk);
		fire = 1'b0;
		repeat (int'(w) + 10) @(negedge clk);
	endtask
	task automatic wait_flag;
		for (int i = 0; i < 600 && flag !== 1'b1; i++) @(negedge clk);
		chk("flag", {7'h00, flag}, 8'h01);
	endtask
	task automatic t_reset;
		logic [7:0] v;
		logic [15:0] a[5] = '{`ECT_ADDR_MODE, `ECT_ADDR_FALL, `ECT_ADDR_RISE, `ECT_ADDR_CKSTP, 16'h0000};
		logic [7:0] e[5] = '{`ECT_RST_MODE, `ECT_RST_CAP, `ECT_RST_CAP, `ECT_RST_CKSTP, 8'h00};
		wr(`ECT_ADDR_RISE, 8'h5A);
		for (int i = 0; i < 5; i++) begin
			rd(a[i], v);
			chk("reset val", v, e[i]);
		end
		$display("test reset done");
	endtask
	task automatic t_clk_sel;
		logic [7:0] v;
		int d[4] = '{64, 32, 2, 16};
		psel = 1'b1;
		for (int s = 0; s < 4; s++) begin
			nf = (s == 2);
			spm = (s == 3);
			wr(`ECT_ADDR_MODE, 8'h0C | 8'(s));
			pulse(8'd20);
			clr;
			pulse(8'd128);
			chk("rise flag", {7'h00, flag}, 8'h01);
			rd(`ECT_ADDR_RISE, v);
			chk("rise cap", {7'h00, v >= 128 / d[s] - 1 && v <= 128 / d[s] + 1}, 8'h01);
		end
		spm = 1'b0;
		nf = 1'b0;
		$display("test clk_sel done");
	endtask
	task automatic t_fall;
		logic [7:0] v;
		wr(`ECT_ADDR_MODE, 8'h16);
		clr;
		pulse(8'd20);
		chk("fall flag", {7'h00, flag}, 8'h01);
		chk("irq", {7'h00, irq}, 8'h01);
		ien = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq off", {7'h00, irq}, 8'h00);
		ien = 1'b1;
		pulse(8'd20);
		rd(`ECT_ADDR_FALL, v);
		chk("fall cap", {7'h00, v >= 15 && v <= 17}, 8'h01);
		$display("test fall done");
	endtask
	task automatic t_ovf;
		logic [7:0] v;
		psel = 1'b0;
		wr(`ECT_ADDR_MODE, 8'h22);
		clr;
		wait_flag;
		rd(`ECT_ADDR_MODE, v);
		chk("ovf low", v, 8'h62);
		wr(`ECT_ADDR_MODE, 8'h22);
		rd(`ECT_ADDR_MODE, v);
		chk("ovf clear", v, 8'h22);
		psel = 1'b1;
		repeat (8) @(negedge clk);
		clr;
		wait_flag;
		rd(`ECT_ADDR_MODE, v);
		chk("ovf high", v, 8'hA2);
		$display("test ovf done");
	endtask
	task automatic t_stby;
		logic [7:0] v;
		wr(`ECT_ADDR_CKSTP, 8'hF7);
		rd(`ECT_ADDR_CKSTP, v);
		chk("ckstp", v, 8'hF7);
		clr;
		repeat (600) @(negedge clk);
		chk("stby flag", {7'h00, flag}, 8'h00);
		wr(`ECT_ADDR_CKSTP, 8'hFF);
		ce = 1'b0;
		repeat (600) @(negedge clk);
		chk("ce flag", {7'h00, flag}, 8'h00);
		ce = 1'b1;
		spm = 1'b1;
		repeat (600) @(negedge clk);
		chk("lowpwr flag", {7'h00, flag}, 8'h00);
		spm = 1'b0;
		$display("test stby done");
	endtask
	task automatic results;
		$display("checks %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_reset;
		t_clk_sel;
		t_fall;
		t_ovf;
		t_stby;
		results;
	end
	initial begin
		#2000000;
		n_errors++;
		results;
	end
endmodule
`default_nettype wire
